// >>> rtl/dpd_ctrl.sv
// Controller end: makes the link clock, sequences commands and power-down.
// Assumes software on AHB-Lite; one slave, single word transfers.
//
// Register access over AHB-Lite and the address map were left to the implementer.
`timescale 1ns/1ps
`include "dpd_cfg.svh"
module dpd_ctrl #(
  parameter int HALF   = `DPD_CK_HALF,
  parameter int CKEMIN = `DPD_CKE_MIN_CK,
  parameter int CPDED  = `DPD_CPDED_CK,
  parameter int XP     = `DPD_XP_CK,
  parameter int BUSY   = `DPD_BUSY_CK,
  parameter int PDMAX  = `DPD_PD_MAX_CK
) (
  input  wire logic        CLK,
  input  wire logic        RSTN,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  dpd_link_if.ctrl         LINK
);
  localparam int ENTRY_CK = (CPDED > CKEMIN) ? CPDED : CKEMIN;
  localparam int EXIT_CK  = (XP > CKEMIN) ? XP : CKEMIN;

  logic [3:0]  ctrl_reg;
  logic [16:0] cmdw_reg;
  logic        pend_reg;
  logic        dllrst_reg;
  logic        tmo_reg;
  logic        unl_reg;
  logic        dph_reg;
  logic        wr_reg;
  logic [7:0]  adr_reg;
  dpd_pkg::dpd_cst_t st_reg;
  logic [7:0]  cnt_reg;
  logic [7:0]  busy_reg;
  logic [7:0]  div_reg;
  logic        ck_reg;
  logic        cke_reg;
  logic        rstn_reg;
  logic        odt_reg;
  logic [3:0]  cmd_reg;
  logic [2:0]  ba_reg;
  logic [8:0]  addr_reg;

  wire        fall    = ck_reg && div_reg == 8'(HALF - 1);
  wire        a_take  = HSEL && HTRANS[1] && HREADY;
  wire        w_ctrl  = dph_reg && wr_reg && adr_reg == `DPD_CTRL_OFS;
  wire        w_cmd   = dph_reg && wr_reg && adr_reg == `DPD_CMD_OFS;
  wire        w_stat  = dph_reg && wr_reg && adr_reg == `DPD_STAT_OFS;
  wire        in_pd   = st_reg == dpd_pkg::DPD_C_ENTRY || st_reg == dpd_pkg::DPD_C_PD;
  wire [3:0]  pop     = cmdw_reg[3:0];
  wire        long_op = pop == dpd_pkg::DPD_RD || pop == dpd_pkg::DPD_WR || pop == dpd_pkg::DPD_MRS ||
                        pop == dpd_pkg::DPD_ZQ || pop == dpd_pkg::DPD_MPA;
  // Link reset is frozen in power-down, so it must already be high and not requested low
  wire        can_pd  = ctrl_reg[`DPD_CTRL_PDREQ] && !tmo_reg && busy_reg == 8'h00 && !pend_reg &&
                        rstn_reg && !ctrl_reg[`DPD_CTRL_RST];
  wire        pd_end  = !ctrl_reg[`DPD_CTRL_PDREQ] || cnt_reg >= 8'(PDMAX - 1);
  wire [31:0] stat    = {24'h0, st_reg, tmo_reg, dllrst_reg, busy_reg != 8'h00, pend_reg, in_pd};
  wire [31:0] rd_mux  = (adr_reg == `DPD_CTRL_OFS) ? {28'h0, ctrl_reg} :
                        (adr_reg == `DPD_CMD_OFS)  ? {15'h0, cmdw_reg} :
                        (adr_reg == `DPD_STAT_OFS) ? stat : 32'h0;

  assign LINK.ck    = ck_reg;
  assign LINK.cke   = cke_reg;
  assign LINK.rst_n = rstn_reg;
  assign LINK.termination_control_input   = odt_reg;
  assign LINK.cmd   = cmd_reg;
  assign LINK.ba    = ba_reg;
  assign LINK.addr  = addr_reg;

  // Bus slave: one wait state so read data leaves a flip-flop
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      dph_reg   <= 1'b0;
      wr_reg    <= 1'b0;
      adr_reg   <= 8'h00;
      HRDATA    <= 32'h0;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else if (dph_reg) begin
      dph_reg   <= 1'b0;
      HRDATA    <= wr_reg ? 32'h0 : rd_mux;
      HREADYOUT <= 1'b1;
    end else if (a_take) begin
      dph_reg   <= 1'b1;
      wr_reg    <= HWRITE;
      adr_reg   <= HADDR[7:0];
      HREADYOUT <= 1'b0;
    end
  end

  // Software registers; hardware sets win over software clears
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      ctrl_reg <= 4'h0;
      cmdw_reg <= 17'h0;
      pend_reg <= 1'b0;
    end else begin
      if (w_ctrl) ctrl_reg <= HWDATA[3:0];
      if (w_cmd && !pend_reg) begin
        cmdw_reg <= HWDATA[16:0];
        pend_reg <= HWDATA[3:0] != dpd_pkg::DPD_DES;
      end else if (fall && st_reg == dpd_pkg::DPD_C_IDLE && pend_reg && busy_reg == 8'h00 &&
                   !can_pd) begin
        pend_reg <= 1'b0;
      end
    end
  end

  // Link clock divider
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      div_reg <= 8'h00;
      ck_reg  <= 1'b0;
    end else if (div_reg == 8'(HALF - 1)) begin
      div_reg <= 8'h00;
      ck_reg  <= !ck_reg;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  // Link sequencer; every link signal changes on the falling link clock edge
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      st_reg     <= dpd_pkg::DPD_C_IDLE;
      cnt_reg    <= 8'h00;
      busy_reg   <= 8'h00;
      cke_reg    <= 1'b1;
      rstn_reg   <= 1'b0;
      odt_reg    <= 1'b0;
      cmd_reg    <= dpd_pkg::DPD_DES;
      ba_reg     <= 3'h0;
      addr_reg   <= 9'h000;
      unl_reg    <= 1'b0;
      dllrst_reg <= 1'b0;
      tmo_reg    <= 1'b0;
    end else begin
      if (w_stat && HWDATA[`DPD_STAT_DLLRST]) dllrst_reg <= 1'b0;
      if (w_stat && HWDATA[`DPD_STAT_TMO]) tmo_reg <= 1'b0;
      if (fall) begin
        // Termination input always driven valid, including during power-down
        odt_reg <= ctrl_reg[`DPD_CTRL_ODT];
        // Reset is only released or asserted outside power-down
        if (!in_pd) rstn_reg <= !ctrl_reg[`DPD_CTRL_RST];
        if (busy_reg != 8'h00) busy_reg <= busy_reg - 8'h01;
        unique case (st_reg)
          dpd_pkg::DPD_C_IDLE: begin
            if (can_pd) begin
              st_reg  <= dpd_pkg::DPD_C_ENTRY;
              cke_reg <= 1'b0;
              cmd_reg <= dpd_pkg::DPD_DES;
              cnt_reg <= 8'(ENTRY_CK - 1);
              unl_reg <= ctrl_reg[`DPD_CTRL_DLLUNL];
            end else if (pend_reg && busy_reg == 8'h00) begin
              st_reg   <= dpd_pkg::DPD_C_CMD;
              cmd_reg  <= pop;
              ba_reg   <= cmdw_reg[6:4];
              addr_reg <= cmdw_reg[16:8];
              if (long_op) busy_reg <= 8'(BUSY);
            end
          end
          dpd_pkg::DPD_C_CMD: begin
            st_reg  <= dpd_pkg::DPD_C_IDLE;
            cmd_reg <= dpd_pkg::DPD_DES;
          end
          dpd_pkg::DPD_C_ENTRY: begin
            // Deselect and low enable held for window and minimum pulse
            cnt_reg <= cnt_reg - 8'h01;
            if (cnt_reg == 8'h00) begin
              st_reg  <= dpd_pkg::DPD_C_PD;
              cnt_reg <= 8'(ENTRY_CK);
            end
          end
          dpd_pkg::DPD_C_PD: begin
            cnt_reg <= cnt_reg + 8'h01;
            if (pd_end) begin
              st_reg  <= dpd_pkg::DPD_C_EXIT;
              cke_reg <= 1'b1;
              cmd_reg <= dpd_pkg::DPD_DES;
              cnt_reg <= 8'(EXIT_CK - 1);
              if (ctrl_reg[`DPD_CTRL_PDREQ]) tmo_reg <= 1'b1;
              if (unl_reg) dllrst_reg <= 1'b1;
            end
          end
          dpd_pkg::DPD_C_EXIT: begin
            // No command until exit delay and high pulse have both run
            cnt_reg <= cnt_reg - 8'h01;
            if (cnt_reg == 8'h00) st_reg <= dpd_pkg::DPD_C_IDLE;
          end
          default: st_reg <= dpd_pkg::DPD_C_IDLE;
        endcase
      end
    end
  end
endmodule // dpd_ctrl

// >>> rtl/dpd_cfg.svh
// Constants for the power-down link: timing counts, register map, fields.
// Assumes CLK at 10 MHz and a link clock made by dividing CLK.
`ifndef DPD_CFG_SVH
`define DPD_CFG_SVH
`define DPD_CLK_NS      100
`define DPD_CK_NS       800
`define DPD_CK_HALF     (`DPD_CK_NS / `DPD_CLK_NS / 2)
`define DPD_CKE_MIN_CK  3
`define DPD_CPDED_CK    4
`define DPD_XP_CK       4
`define DPD_OP_CK       4
`define DPD_BUSY_CK     6
`define DPD_REFI_NS     7800
`define DPD_PD_MAX_REFI 9
`define DPD_PD_MAX_CK   (`DPD_PD_MAX_REFI * `DPD_REFI_NS / `DPD_CK_NS)
`define DPD_CTRL_OFS    8'h00
`define DPD_CMD_OFS     8'h04
`define DPD_STAT_OFS    8'h08
`define DPD_CTRL_PDREQ  0
`define DPD_CTRL_DLLUNL 1
`define DPD_CTRL_ODT    2
`define DPD_CTRL_RST    3
`define DPD_STAT_DLLRST 3
`define DPD_STAT_TMO    4
`define DPD_TMODE_BA    3'h5
`define DPD_BUF_OFF_BIT 5
`define DPD_PARK_LSB    6
`endif

// >>> rtl/dpd_pkg.sv
// Types shared by both ends of the power-down link.
// Assumes dpd_cfg.svh for numeric constants.
package dpd_pkg;
  typedef enum logic [3:0] {
    DPD_DES = 4'h0, DPD_ACT = 4'h1, DPD_PRE = 4'h2, DPD_PREA = 4'h3, DPD_REF = 4'h4,
    DPD_RD  = 4'h5, DPD_WR  = 4'h6, DPD_MRS = 4'h7, DPD_ZQ   = 4'h8, DPD_MPA = 4'h9
  } dpd_cmd_t;
  typedef enum logic [1:0] {
    DPD_PD_NONE = 2'h0, DPD_PD_PRE = 2'h1, DPD_PD_ACT = 2'h2, DPD_PD_WAIT = 2'h3
  } dpd_pd_t;
  typedef enum logic [2:0] {
    DPD_D_UP = 3'h0, DPD_D_WAIT = 3'h1, DPD_D_PPD = 3'h2, DPD_D_APD = 3'h3,
    DPD_D_XP = 3'h4, DPD_D_RST = 3'h5
  } dpd_dst_t;
  typedef enum logic [2:0] {
    DPD_C_IDLE = 3'h0, DPD_C_CMD = 3'h1, DPD_C_ENTRY = 3'h2, DPD_C_PD = 3'h3, DPD_C_EXIT = 3'h4
  } dpd_cst_t;
endpackage

// >>> rtl/dpd_link_if.sv
// Link between controller and memory power-down logic.
// All signals are driven by the controller; the memory samples them.
`timescale 1ns/1ps
interface dpd_link_if;
  logic       ck;
  logic       cke;
  logic       rst_n;
  logic       termination_control_input;
  logic [3:0] cmd;
  logic [2:0] ba;
  logic [8:0] addr;
  modport ctrl (output ck, output cke, output rst_n, output termination_control_input, output cmd, output ba, output addr);
  modport dram (input ck, input cke, input rst_n, input termination_control_input, input cmd, input ba, input addr);
endinterface

// >>> rtl/dpd_sync.sv
// Three-stage input synchroniser; a bit changes once stages two and three agree.
// Assumes asynchronous inputs relative to CLK.
`timescale 1ns/1ps
module dpd_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  wire  [W-1:0] agree = ~(s2_reg ^ s3_reg);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      q      <= '0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q      <= (s3_reg & agree) | (q & ~agree);
    end
  end
endmodule // dpd_sync

// >>> rtl/dpd_dram.sv
// Memory end: power-down entry/exit, buffer and termination gating.
// Assumes link signals change away from the rising link clock edge.
`timescale 1ns/1ps
`include "dpd_cfg.svh"
module dpd_dram #(
  parameter int NBANK  = 8,
  parameter int CKEMIN = `DPD_CKE_MIN_CK,
  parameter int CPDED  = `DPD_CPDED_CK,
  parameter int XP     = `DPD_XP_CK,
  parameter int OPCK   = `DPD_OP_CK
) (
  input  wire logic       CLK,
  input  wire logic       RSTN,
  dpd_link_if.dram        LINK,
  output logic      [1:0] PD_STATE,
  output logic            IN_BUF_ON,
  output logic            CMD_RX_ON,
  output logic            ODT_BUF_ON,
  output logic            NOM_TERM_ON,
  output logic            PARK_ON,
  output logic            DLL_ON,
  output logic            IN_RESET,
  output logic            VIOL
);
  logic [19:0]      s;
  logic             ck_d_reg;
  dpd_pkg::dpd_dst_t st_reg;
  logic [NBANK-1:0] bank_reg;
  logic             buf_off_reg;
  logic [2:0]       park_reg;
  logic [7:0]       op_reg;
  logic [7:0]       win_reg;
  logic [7:0]       pdc_reg;
  logic [7:0]       xp_reg;

  dpd_sync #(.W(20)) u_sync (
    .clk  (CLK),
    .rstn (RSTN),
    .d    ({LINK.ck, LINK.cke, LINK.rst_n, LINK.termination_control_input, LINK.cmd, LINK.ba, LINK.addr}),
    .q    (s)
  );

  wire       ck_s   = s[19];
  wire       cke_s  = s[18];
  wire       rstn_s = s[17];
  wire       odt_s  = s[16];
  wire [3:0] cmd_s  = s[15:12];
  wire [2:0] ba_s   = s[11:9];
  wire [8:0] addr_s = s[8:0];
  wire       rise   = ck_s & ~ck_d_reg;
  wire       des    = cmd_s == dpd_pkg::DPD_DES;
  wire       up     = st_reg == dpd_pkg::DPD_D_UP;
  wire       in_pd  = (st_reg == dpd_pkg::DPD_D_WAIT) || (st_reg == dpd_pkg::DPD_D_PPD) ||
                      (st_reg == dpd_pkg::DPD_D_APD);
  wire       bank_op = (cmd_s == dpd_pkg::DPD_ACT) || (cmd_s == dpd_pkg::DPD_PRE) ||
                       (cmd_s == dpd_pkg::DPD_PREA) || (cmd_s == dpd_pkg::DPD_REF);
  wire [NBANK-1:0] ba_hot = NBANK'(1) << ba_s;
  wire       enter  = up && !cke_s && des;
  wire       leave  = in_pd && cke_s && des;

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      ck_d_reg    <= 1'b0;
      st_reg      <= dpd_pkg::DPD_D_RST;
      bank_reg    <= '0;
      buf_off_reg <= 1'b0;
      park_reg    <= 3'h0;
      op_reg      <= 8'h00;
      win_reg     <= 8'h00;
      pdc_reg     <= 8'h00;
      xp_reg      <= 8'h00;
      VIOL        <= 1'b0;
    end else begin
      ck_d_reg <= ck_s;
      if (rise) begin
        if (!rstn_s) begin
          st_reg      <= dpd_pkg::DPD_D_RST;
          bank_reg    <= '0;
          buf_off_reg <= 1'b0;
          park_reg    <= 3'h0;
          op_reg      <= 8'h00;
          VIOL        <= 1'b0;
        end else begin
          if (op_reg != 8'h00) op_reg <= op_reg - 8'h01;
          // Ops begun before entry keep running; new ones only decode when awake
          if (up && bank_op) op_reg <= 8'(OPCK);
          if (up && cmd_s == dpd_pkg::DPD_ACT) bank_reg <= bank_reg | ba_hot;
          if (up && cmd_s == dpd_pkg::DPD_PRE) bank_reg <= bank_reg & ~ba_hot;
          if (up && cmd_s == dpd_pkg::DPD_PREA) bank_reg <= '0;
          if (up && cmd_s == dpd_pkg::DPD_MRS && ba_s == `DPD_TMODE_BA) begin
            buf_off_reg <= addr_s[`DPD_BUF_OFF_BIT];
            park_reg    <= addr_s[`DPD_PARK_LSB +: 3];
          end
          if (win_reg != 8'h00) begin
            win_reg <= win_reg - 8'h01;
            if (!des) VIOL <= 1'b1;
          end
          if (in_pd) pdc_reg <= pdc_reg + 8'h01;
          unique case (st_reg)
            dpd_pkg::DPD_D_RST: st_reg <= dpd_pkg::DPD_D_UP;
            dpd_pkg::DPD_D_UP: begin
              if (enter) begin
                st_reg  <= dpd_pkg::DPD_D_WAIT;
                win_reg <= 8'(CPDED);
                pdc_reg <= 8'h01;
              end
            end
            dpd_pkg::DPD_D_WAIT, dpd_pkg::DPD_D_PPD, dpd_pkg::DPD_D_APD: begin
              if (leave) begin
                st_reg  <= dpd_pkg::DPD_D_XP;
                xp_reg  <= 8'(XP - 1);
                win_reg <= 8'h00;
                if (pdc_reg < 8'(CKEMIN)) VIOL <= 1'b1;
              end else if (st_reg == dpd_pkg::DPD_D_WAIT && op_reg == 8'h00) begin
                st_reg <= (bank_reg == '0) ? dpd_pkg::DPD_D_PPD : dpd_pkg::DPD_D_APD;
              end
            end
            dpd_pkg::DPD_D_XP: begin
              if (!des) VIOL <= 1'b1;
              if (xp_reg <= 8'h01) st_reg <= dpd_pkg::DPD_D_UP;
              xp_reg <= xp_reg - 8'h01;
            end
            default: st_reg <= dpd_pkg::DPD_D_RST;
          endcase
        end
      end
    end
  end

  // Status outputs are registered one CLK after the state they reflect
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      PD_STATE    <= dpd_pkg::DPD_PD_NONE;
      IN_BUF_ON   <= 1'b0;
      CMD_RX_ON   <= 1'b0;
      ODT_BUF_ON  <= 1'b0;
      NOM_TERM_ON <= 1'b0;
      PARK_ON     <= 1'b0;
      DLL_ON      <= 1'b0;
      IN_RESET    <= 1'b1;
    end else begin
      PD_STATE    <= (st_reg == dpd_pkg::DPD_D_PPD) ? dpd_pkg::DPD_PD_PRE :
                     (st_reg == dpd_pkg::DPD_D_APD) ? dpd_pkg::DPD_PD_ACT :
                     (st_reg == dpd_pkg::DPD_D_WAIT) ? dpd_pkg::DPD_PD_WAIT : dpd_pkg::DPD_PD_NONE;
      IN_BUF_ON   <= !in_pd && st_reg != dpd_pkg::DPD_D_RST;
      CMD_RX_ON   <= !(in_pd && win_reg == 8'h00) && st_reg != dpd_pkg::DPD_D_RST;
      ODT_BUF_ON  <= !(in_pd && buf_off_reg);
      NOM_TERM_ON <= odt_s && !(in_pd && buf_off_reg);
      PARK_ON     <= park_reg != 3'h0;
      DLL_ON      <= st_reg != dpd_pkg::DPD_D_RST;
      IN_RESET    <= st_reg == dpd_pkg::DPD_D_RST;
    end
  end
endmodule // dpd_dram

// >>> bench/dpd_link_sva.sv
// Checker for the power-down link: watches the wires and the memory end's status.
// Assumes all watched signals are registers on CLK; instantiated in tb_top beside the link.
`timescale 1ns/1ps
module dpd_link_sva #(
  parameter int WIN_CLK  = 31,
  parameter int BUSY_CLK = 15,
  parameter int MIN_CLK  = 24
) (
  input logic       CLK,
  input logic       RSTN,
  input logic       ck,
  input logic       cke,
  input logic       rst_n,
  input logic [3:0] cmd,
  input logic [1:0] PD_STATE,
  input logic       CMD_RX_ON,
  input logic       ODT_BUF_ON,
  input logic       NOM_TERM_ON,
  input logic       DLL_ON,
  input logic       IN_RESET
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  logic [7:0] hold_cnt;
  // Read, write, mode set, calibration and multipurpose access
  wire        busy_cmd = cmd inside {4'h5, 4'h6, 4'h7, 4'h8, 4'h9};
  // Saturating count of cycles that cke has stood at its level
  always_ff @(posedge CLK) begin
    if (!RSTN || $changed(cke)) begin
      hold_cnt <= 8'h00;
    end else if (hold_cnt != 8'hff) begin
      hold_cnt <= hold_cnt + 8'h01;
    end
  end
  sequence s_enter;
    $fell(cke) && cmd == dpd_pkg::DPD_DES;
  endsequence
  sequence s_leave;
    $rose(cke) && cmd == dpd_pkg::DPD_DES;
  endsequence
  AST_ENTRY_DES: assert property ($fell(cke) |-> cmd == dpd_pkg::DPD_DES)
    else $error("cke fell without deselect");
  AST_EXIT_DES: assert property ($rose(cke) |-> cmd == dpd_pkg::DPD_DES)
    else $error("cke rose without deselect");
  AST_ENTRY_WIN: assert property (s_enter |-> (cmd == dpd_pkg::DPD_DES && !cke) throughout (##WIN_CLK 1'b1))
    else $error("entry window broken");
  AST_EXIT_WAIT: assert property (s_leave |-> (cmd == dpd_pkg::DPD_DES && cke) throughout (##WIN_CLK 1'b1))
    else $error("command before exit delay");
  AST_BUSY_HOLD: assert property ($changed(cmd) && busy_cmd |-> cke throughout (##BUSY_CLK 1'b1))
    else $error("entry during busy operation");
  AST_PULSE_MIN: assert property ($changed(cke) |-> hold_cnt >= MIN_CLK - 1)
    else $error("cke pulse too short");
  AST_RST_STEADY: assert property (!cke |-> $stable(rst_n))
    else $error("link reset moved in power-down");
  AST_PD_ENTER: assert property (s_enter |-> ##[1:16] PD_STATE != 2'h0)
    else $error("memory did not enter power-down");
  AST_PD_EXIT: assert property (s_leave |-> ##[1:16] PD_STATE == 2'h0)
    else $error("memory did not leave power-down");
  AST_RX_WINDOW: assert property (s_enter |-> (CMD_RX_ON throughout (##24 1'b1)) ##[1:40] !CMD_RX_ON)
    else $error("receivers gated at wrong time");
  AST_TERM_GATE: assert property (NOM_TERM_ON |-> ODT_BUF_ON)
    else $error("termination on with buffer off");
  AST_DLL_KEPT: assert property (!IN_RESET |-> DLL_ON)
    else $error("DLL off outside reset");
  AST_LINK_ON_FALL: assert property ($changed(cmd) || $changed(cke) || $changed(rst_n) |-> $fell(ck))
    else $error("link signal moved away from falling link clock");
endmodule // dpd_link_sva

// >>> bench/tb_top.sv
// Self-checking bench: software drives the controller over AHB-Lite, the memory end follows the link.
// Assumes shortened busy and timeout counts, set at the controller instance below.
`timescale 1ns/1ps
`include "dpd_cfg.svh"
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin err_total++; $display("MISMATCH %s exp %h got %h", n, e, a); end end
`define WAITC(c) for (int w = 0; w < 300 && !(c); w++) @(posedge clk)
module tb_top;
  logic        clk    = 1'b0;
  logic        rstn   = 1'b0;
  logic        hsel   = 1'b0;
  logic [31:0] haddr  = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [2:0]  hsize  = 3'h0;
  logic [31:0] rdat;
  wire  [31:0] hrdata;
  wire         hrdy;
  wire         hresp;
  wire  [1:0]  pd_state;
  wire         in_buf_on, cmd_rx_on, odt_buf_on, nom_term_on, park_on, dll_on, in_reset, viol;
  int          err_total   = 0;
  int          check_count = 0;
  dpd_link_if link ();
  dpd_ctrl #(.BUSY(2), .PDMAX(10)) dpd_ctrl_inst (
    .CLK(clk), .RSTN(rstn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hrdy), .HRDATA(hrdata), .HREADYOUT(hrdy),
    .HRESP(hresp), .LINK(link.ctrl));
  dpd_dram dpd_dram_inst (
    .CLK(clk), .RSTN(rstn), .LINK(link.dram), .PD_STATE(pd_state), .IN_BUF_ON(in_buf_on),
    .CMD_RX_ON(cmd_rx_on), .ODT_BUF_ON(odt_buf_on), .NOM_TERM_ON(nom_term_on),
    .PARK_ON(park_on), .DLL_ON(dll_on), .IN_RESET(in_reset), .VIOL(viol));
  // Window and busy spans stop one cycle short of the earliest legal next step
  dpd_link_sva #(.WIN_CLK(31), .BUSY_CLK(15), .MIN_CLK(24)) dpd_link_sva_inst (
    .CLK(clk), .RSTN(rstn), .ck(link.ck), .cke(link.cke), .rst_n(link.rst_n), .cmd(link.cmd),
    .PD_STATE(pd_state), .CMD_RX_ON(cmd_rx_on), .ODT_BUF_ON(odt_buf_on),
    .NOM_TERM_ON(nom_term_on), .DLL_ON(dll_on), .IN_RESET(in_reset));

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= w;
    hsize  <= 3'h2;
    htrans <= 2'h2;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    rdat = hrdata;
    `CHK("hresp", 1'b0, hresp)
  endtask

  task automatic poll(input logic [31:0] m, input logic [31:0] v);
    for (int i = 0; i < 400; i++) begin
      ahb(1'b0, `DPD_STAT_OFS, 32'h0);
      if ((rdat & m) === v) return;
    end
    `CHK("status_poll", v, rdat & m)
  endtask

  task automatic cmd(input logic [3:0] op, input logic [2:0] b, input logic [8:0] a);
    ahb(1'b1, `DPD_CMD_OFS, {15'h0, a, 1'b0, b, op});
    poll(32'h6, 32'h0);
  endtask

  task automatic pd(input logic [31:0] c);
    ahb(1'b1, `DPD_CTRL_OFS, c);
    poll(32'h1, 32'h1);
    `WAITC((pd_state === 2'h1 || pd_state === 2'h2) && cmd_rx_on === 1'b0);
  endtask

  task automatic leave();
    ahb(1'b1, `DPD_CTRL_OFS, 32'h0);
    poll(32'he0, 32'h0);
  endtask

  task automatic end_of_test();
    if (err_total == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    forever #50 clk = ~clk;
  end

  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    end_of_test();
  end

  initial begin
    logic [3:0] op;
    void'($urandom(32'h8be1));
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    `CHK("in_reset", 1'b1, in_reset)
    ahb(1'b0, `DPD_STAT_OFS, 32'h0);
    `CHK("stat_rst", 32'h0, rdat)
    ahb(1'b1, `DPD_CTRL_OFS, 32'h0);
    `WAITC(in_reset === 1'b0);
    `CHK("dll_on", 1'b1, dll_on)
    ahb(1'b1, 8'h10, $urandom);
    ahb(1'b0, 8'h10, 32'h0);
    `CHK("unmapped", 32'h0, rdat)
    // Park value 3 with the termination buffer switched off
    cmd(dpd_pkg::DPD_MRS, `DPD_TMODE_BA, 9'h0e0);
    `CHK("park_on", 1'b1, park_on)
    repeat (8) begin
      op = 4'($urandom_range(9, 1));
      cmd(op, (op == dpd_pkg::DPD_MRS) ? 3'h0 : 3'($urandom_range(7, 0)), 9'($urandom));
    end
    // Activate right before entry: the memory must finish it first
    cmd(dpd_pkg::DPD_ACT, 3'h2, 9'h0);
    pd(32'h1);
    `CHK("apd_state", 2'h2, pd_state)
    `CHK("in_buf_pd", 1'b0, in_buf_on)
    `CHK("rx_pd", 1'b0, cmd_rx_on)
    `CHK("odt_buf_off", 1'b0, odt_buf_on)
    `CHK("park_pd", 1'b1, park_on)
    `CHK("dll_pd", 1'b1, dll_on)
    leave();
    `CHK("exit_state", 2'h0, pd_state)
    `CHK("in_buf_up", 1'b1, in_buf_on)
    `CHK("viol", 1'b0, viol)
    cmd(dpd_pkg::DPD_MRS, `DPD_TMODE_BA, 9'h000);
    cmd(dpd_pkg::DPD_PREA, 3'h0, 9'h0);
    pd(32'h5);
    `CHK("ppd_state", 2'h1, pd_state)
    `CHK("odt_buf_on", 1'b1, odt_buf_on)
    `CHK("nom_term", 1'b1, nom_term_on)
    `CHK("park_off", 1'b0, park_on)
    leave();
    // Unlocked DLL and a stay long enough to hit the timeout
    ahb(1'b1, `DPD_CTRL_OFS, 32'h3);
    poll(32'h10, 32'h10);
    poll(32'he0, 32'h0);
    `CHK("tmo_exit", 2'h0, pd_state)
    ahb(1'b0, `DPD_STAT_OFS, 32'h0);
    `CHK("dll_rst_flag", 32'h8, rdat & 32'h8)
    ahb(1'b1, `DPD_CTRL_OFS, 32'h0);
    ahb(1'b1, `DPD_STAT_OFS, 32'h18);
    ahb(1'b0, `DPD_STAT_OFS, 32'h0);
    `CHK("flags_clr", 32'h0, rdat & 32'h18)
    // Link reset clears the breach flag, so look at it first
    `CHK("viol_end", 1'b0, viol)
    ahb(1'b1, `DPD_CTRL_OFS, 32'h8);
    `WAITC(in_reset === 1'b1);
    `CHK("link_reset", 1'b1, in_reset)
    `CHK("dll_reset", 1'b0, dll_on)
    end_of_test();
  end
endmodule // tb_top
